/* File: pkg/e1tm_pkg.sv */
package e1tm_pkg;

  // ****************************************************************
  // Register indices (byte address = 4 x index)
  // ****************************************************************
  localparam logic [9:0] IDX_FRAME_MODE = 10'h060;
  localparam logic [9:0] IDX_TX_ALARM = 10'h06b;
  localparam logic [9:0] IDX_TX_MAINT = 10'h06c;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h06d;
  localparam logic [9:0] IDX_IRQ_FLAGS = 10'h06e;
  localparam logic [9:0] IDX_ERR_INSERT = 10'h06f;
  localparam logic [9:0] IDX_CLK_SOURCE = 10'h070;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [2:0] RST_FRAME_MODE = 3'h0;
  localparam logic [2:0] RST_TX_ALARM = 3'h0;
  localparam logic [2:0] RST_TX_MAINT = 3'h0;
  localparam logic [4:0] RST_IRQ_ENABLE = 5'h00;
  localparam logic [4:0] RST_IRQ_FLAGS = 5'h00;
  localparam logic [5:0] RST_ERR_INSERT = 6'h00;
  localparam logic RST_CLK_SOURCE = 1'b0;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MODE_CRC_MF = 0;
  localparam int MODE_CAS_MF = 1;
  localparam int MODE_CLK_MASTER = 2;
  localparam int ALM_MANUAL = 0;
  localparam int ALM_AUTO_EN = 1;
  localparam int ALM_CRITERIA = 2;
  localparam int MNT_ONES_FORCE = 0;
  localparam int MNT_ZERO_FORCE = 1;
  localparam int MNT_SLIP_TOGGLE = 2;
  localparam int FLG_BASIC_FRAME = 0;
  localparam int FLG_CRC_MF = 1;
  localparam int FLG_SIG_MF = 2;
  localparam int FLG_ALIGN_WORD = 3;
  localparam int FLG_SUB_MF = 4;
  localparam int ERR_FAS_BIT = 0;
  localparam int ERR_FAS_ALL = 1;
  localparam int ERR_NFAS = 2;
  localparam int ERR_SIG_ALIGN = 3;
  localparam int ERR_CRC_ALIGN = 4;
  localparam int ERR_CRC_BITS = 5;

  // ****************************************************************
  // Frame patterns
  // ****************************************************************
  localparam logic [6:0] FAS_PATTERN = 7'h1b;
  localparam logic [5:0] CRC_MF_PATTERN = 6'h0b;
  localparam logic [3:0] SIG_MF_XY = 4'hb;
  localparam logic [3:0] CRC4_POLY = 4'h3;
  localparam logic [7:0] LFSR_SEED = 8'h01;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 10000;
  localparam int BIT_PERIOD_PS = 488281;
  localparam int BIT_CYCLES = BIT_PERIOD_PS / CLK_PERIOD_PS;
  localparam logic [5:0] BIT_LAST = 6'(BIT_CYCLES - 1);

  // ****************************************************************
  // Transmit clock source
  // ****************************************************************
  typedef enum logic [1:0] {
    E1TM_CLK_INTERNAL = 2'h0,
    E1TM_CLK_RECOVERED = 2'h1,
    E1TM_CLK_BACKPLANE = 2'h2
  } e1tm_clk_src_t;

endpackage : e1tm_pkg

/* File: design/e1tm_tx_framer_maint.sv */
// Operation
// - With automatic alarm enabled, A bit is 1 whenever selected criteria hold.
// - Manual remote alarm control forces A bit to 1 unconditionally.
// - Each slip control change drops or repeats one bit, chosen at random.
// - Zero-force control replaces the whole outgoing stream with zeros.
// - Ones-force control replaces the whole outgoing stream with ones unless zero-force is also set.
// - Five enable bits 4..0 gate matching flags onto the interrupt pin.
// - Sub-multiframe flag sets at first bit of each CRC sub-multiframe.
// - Alignment-word flag sets at first bit of each frame carrying FAS.
// - Signaling multiframe flag sets at first bit of each signaling multiframe.
// - CRC multiframe flag sets at first bit of each CRC multiframe.
// - Basic frame flag sets at first bit of each basic frame.
// - A flag clears only by writing one to it; zero leaves it.
// - CRC error control edge inverts four CRC bits: the last three C bits of one sub-multiframe and the first C bit of the next.
// - CRC alignment error edge inverts one 001011 multiframe pattern.
// - Signaling alignment error edge inverts one 0000 multiframe pattern.
// - Non-alignment error edge inverts one NFAS bit, TS0 bit 2 odd frame.
// - Full alignment error edge inverts one whole seven-bit FAS.
// - Single alignment error edge inverts exactly one FAS bit.
// - Each error control clears itself when its inversion starts; in a mode where it is not valid it stays set.
// - Master mode: select 0 internal, 1 recovered clock; buffer always bypassed.
// - Slave mode: select 0 backplane and bypass, 1 internal with buffer.
// - Criteria 0: frame loss, interworking, offline loss or manual; 1: loss or manual.
`timescale 1ns/1ps
module e1tm_tx_framer_maint
  import e1tm_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic txDataIn,
  input wire logic rxFrameLoss,
  input wire logic rxCrcInterwork,
  input wire logic rxOfflineLoss,
  output logic txLineData,
  output logic txBitStrobe,
  output logic txIrqN,
  output e1tm_clk_src_t txClkSource,
  output logic txBufferBypass
);

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic [2:0] frameMode;
  logic [2:0] txAlarmCtrl;
  logic [2:0] txMaintCtrl;
  logic [4:0] irqEnable;
  logic [4:0] irqFlags;
  logic [5:0] errInsert;
  logic clkSourceSel;
  logic ackDone;
  logic [5:0] bitDiv;
  logic bitTick;
  logic [7:0] bitPos;
  logic [3:0] frameNum;
  logic [2:0] dataSync;
  logic dataStable;
  logic slipLast;
  logic slipPending;
  logic [7:0] lfsr;
  logic [3:0] crcAcc;
  logic [3:0] crcOut;
  logic [5:0] errActive;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire [9:0] regIndex = address[11:2];
  wire hitMode = (regIndex == IDX_FRAME_MODE);
  wire hitAlarm = (regIndex == IDX_TX_ALARM);
  wire hitMaint = (regIndex == IDX_TX_MAINT);
  wire hitEnable = (regIndex == IDX_IRQ_ENABLE);
  wire hitFlags = (regIndex == IDX_IRQ_FLAGS);
  wire hitErr = (regIndex == IDX_ERR_INSERT);
  wire hitClk = (regIndex == IDX_CLK_SOURCE);
  wire busReq = read | write;
  wire wrStrobe = write & ackDone & byteenable[0];
  wire [7:0] wrByte = writedata[7:0];

  // Read value mux; unmapped addresses read zero
  wire [7:0] rdByte =
    hitMode ? {5'h00, frameMode} :
    hitAlarm ? {5'h00, txAlarmCtrl} :
    hitMaint ? {5'h00, txMaintCtrl} :
    hitEnable ? {3'h0, irqEnable} :
    hitFlags ? {3'h0, irqFlags} :
    hitErr ? {2'h0, errInsert} :
    hitClk ? {7'h00, clkSourceSel} : 8'h00;

  // One wait cycle on every access
  assign waitrequest = busReq & ~ackDone;

  // ****************************************************************
  // Mode and frame position decode
  // ****************************************************************
  wire crcMode = frameMode[MODE_CRC_MF];
  wire casMode = frameMode[MODE_CAS_MF];
  wire clkMaster = frameMode[MODE_CLK_MASTER];
  wire [4:0] slotNum = bitPos[7:3];
  wire [2:0] bitInSlot = bitPos[2:0];
  wire oddFrame = frameNum[0];
  wire frameStart = (bitPos == 8'h00);
  wire ts0 = (slotNum == 5'h00);
  wire ts16 = (slotNum == 5'h10);

  // Start-of-unit events seen by the generator
  wire [4:0] boundary;
  assign boundary[FLG_BASIC_FRAME] = frameStart;
  assign boundary[FLG_CRC_MF] = frameStart & (frameNum == 4'h0);
  assign boundary[FLG_SIG_MF] = frameStart & (frameNum == 4'h0);
  assign boundary[FLG_ALIGN_WORD] = frameStart & ~oddFrame;
  assign boundary[FLG_SUB_MF] = frameStart & (frameNum[2:0] == 3'h0);

  // Points where a pending error insertion is taken up
  wire [5:0] errStart;
  assign errStart[ERR_FAS_BIT] = frameStart & ~oddFrame;
  assign errStart[ERR_FAS_ALL] = frameStart & ~oddFrame;
  assign errStart[ERR_NFAS] = frameStart & oddFrame;
  assign errStart[ERR_SIG_ALIGN] = frameStart & (frameNum == 4'h0);
  assign errStart[ERR_CRC_ALIGN] = frameStart & (frameNum == 4'h0);
  assign errStart[ERR_CRC_BITS] = frameStart & (frameNum[2:0] == 3'h0);

  // Modes in which each insertion is valid
  wire [5:0] errValid = {crcMode, crcMode, casMode, 3'b111};
  wire [5:0] errTake = {6{bitTick}} & errStart & errInsert & errValid;

  // ****************************************************************
  // Remote alarm
  // ****************************************************************
  wire manualAlarm = txAlarmCtrl[ALM_MANUAL];
  wire autoCause = txAlarmCtrl[ALM_CRITERIA] ?
    (rxFrameLoss | manualAlarm) :
    (rxFrameLoss | rxCrcInterwork | rxOfflineLoss | manualAlarm);
  wire aBit = manualAlarm | (txAlarmCtrl[ALM_AUTO_EN] & autoCause);

  // ****************************************************************
  // Frame bit builder
  // ****************************************************************
  function automatic logic fas_bit(input logic [2:0] b);
    logic [2:0] k;
    k = 3'(3'd7 - b);
    return FAS_PATTERN[k];
  endfunction : fas_bit

  wire [2:0] crcIdx = 3'(3'd5 - frameNum[3:1]);
  wire [1:0] cIdx = 2'(2'd3 - frameNum[2:1]);
  wire crcBitTx = crcOut[cIdx] ^ errActive[ERR_CRC_BITS];
  wire mfasTx = CRC_MF_PATTERN[crcIdx] ^ errActive[ERR_CRC_ALIGN];
  wire siBit = ~crcMode ? 1'b1 :
    ~oddFrame ? crcBitTx :
    (frameNum < 4'hc) ? mfasTx : 1'b1;
  wire fasTx = fas_bit(bitInSlot) ^ errActive[ERR_FAS_ALL] ^
    (errActive[ERR_FAS_BIT] & (bitInSlot == 3'h1));
  wire nfasTx = 1'b1 ^ errActive[ERR_NFAS];
  wire oddTs0 = (bitInSlot == 3'h1) ? nfasTx :
    (bitInSlot == 3'h2) ? aBit : 1'b1;
  wire sigMfSlot = casMode & ts16 & (frameNum == 4'h0);
  wire sigTx = bitInSlot[2] ? SIG_MF_XY[~bitInSlot[1:0]] :
    errActive[ERR_SIG_ALIGN];
  wire crcSlot = ts0 & (bitInSlot == 3'h0) & crcMode & ~oddFrame;
  wire framedBit = (ts0 & (bitInSlot == 3'h0)) ? siBit :
    (ts0 & ~oddFrame) ? fasTx :
    ts0 ? oddTs0 :
    sigMfSlot ? sigTx : dataStable;

  // Forced output; zero-force takes precedence
  wire lineBit = txMaintCtrl[MNT_ZERO_FORCE] ? 1'b0 :
    txMaintCtrl[MNT_ONES_FORCE] ? 1'b1 : framedBit;

  // CRC-4 over the sub-multiframe, C-bit slots counted as zero
  wire crcIn = crcSlot ? 1'b0 : framedBit;
  wire crcFb = crcIn ^ crcAcc[3];
  wire [3:0] next_crcAcc = {crcAcc[2:0], 1'b0} ^ (crcFb ? CRC4_POLY : 4'h0);

  // Position advance: normal 1, drop 2, repeat 0
  wire slipDrop = lfsr[0];
  wire [8:0] posStep = ~slipPending ? 9'h001 : (slipDrop ? 9'h002 : 9'h000);
  wire [8:0] posSum = {1'b0, bitPos} + posStep;

  // ****************************************************************
  // Avalon slave handshake
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      ackDone <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ackDone <= busReq & ~ackDone;
      if (read & ~ackDone) begin
        readdata <= {24'h00_0000, rdByte};
      end
    end
  end

  // Plain control registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      frameMode <= RST_FRAME_MODE;
      txAlarmCtrl <= RST_TX_ALARM;
      txMaintCtrl <= RST_TX_MAINT;
      irqEnable <= RST_IRQ_ENABLE;
      clkSourceSel <= RST_CLK_SOURCE;
    end else if (wrStrobe) begin
      if (hitMode) frameMode <= wrByte[2:0];
      if (hitAlarm) txAlarmCtrl <= wrByte[2:0];
      if (hitMaint) txMaintCtrl <= wrByte[2:0];
      if (hitEnable) irqEnable <= wrByte[4:0];
      if (hitClk) clkSourceSel <= wrByte[0];
    end
  end

  // Sticky flags: write one clears, a new event wins over the clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      irqFlags <= RST_IRQ_FLAGS;
    end else begin
      irqFlags <= (irqFlags & ~((wrStrobe & hitFlags) ? wrByte[4:0] : 5'h00)) |
        ({5{bitTick}} & boundary);
    end
  end

  // Error insertion controls: armed by software, cleared when taken up
  always_ff @(posedge mclk) begin
    if (reset) begin
      errInsert <= RST_ERR_INSERT;
    end else if (wrStrobe & hitErr) begin
      errInsert <= wrByte[5:0] & ~errTake;
    end else begin
      errInsert <= errInsert & ~errTake;
    end
  end

  // Active insertion lasts until the same boundary comes round again
  always_ff @(posedge mclk) begin
    if (reset) begin
      errActive <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (bitTick & errStart[i]) begin
          errActive[i] <= errTake[i];
        end
      end
    end
  end

  // ****************************************************************
  // Bit rate divider and input synchroniser
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      bitDiv <= 6'h00;
      bitTick <= 1'b0;
    end else begin
      bitTick <= (bitDiv == BIT_LAST);
      bitDiv <= (bitDiv == BIT_LAST) ? 6'h00 : 6'(bitDiv + 6'h01);
    end
  end

  // Three stages; value accepted when the last two agree
  always_ff @(posedge mclk) begin
    if (reset) begin
      dataSync <= 3'h0;
      dataStable <= 1'b0;
    end else begin
      dataSync <= {dataSync[1:0], txDataIn};
      if (dataSync[1] == dataSync[2]) begin
        dataStable <= dataSync[2];
      end
    end
  end

  // ****************************************************************
  // Alignment slip and frame counters
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      slipLast <= 1'b0;
      slipPending <= 1'b0;
      lfsr <= LFSR_SEED;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      slipLast <= txMaintCtrl[MNT_SLIP_TOGGLE];
      if (txMaintCtrl[MNT_SLIP_TOGGLE] != slipLast) begin
        slipPending <= 1'b1;
      end else if (bitTick) begin
        slipPending <= 1'b0;
      end
    end
  end

  // Bit position in frame and frame number in multiframe
  always_ff @(posedge mclk) begin
    if (reset) begin
      bitPos <= 8'h00;
      frameNum <= 4'h0;
    end else if (bitTick) begin
      bitPos <= posSum[7:0];
      if (posSum[8]) begin
        frameNum <= 4'(frameNum + 4'h1);
      end
    end
  end

  // CRC accumulate and hand over at each sub-multiframe start
  always_ff @(posedge mclk) begin
    if (reset) begin
      crcAcc <= 4'h0;
      crcOut <= 4'h0;
    end else if (bitTick) begin
      if (boundary[FLG_SUB_MF]) begin
        crcOut <= crcAcc;
        crcAcc <= {3'h0, crcIn} ^ (crcIn ? CRC4_POLY : 4'h0);
      end else begin
        crcAcc <= next_crcAcc;
      end
    end
  end

  // ****************************************************************
  // Line output, interrupt and clock source
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      txLineData <= 1'b0;
      txBitStrobe <= 1'b0;
      txIrqN <= 1'b1;
    end else begin
      txBitStrobe <= bitTick;
      if (bitTick) begin
        txLineData <= lineBit;
      end
      txIrqN <= ~|(irqFlags & irqEnable);
    end
  end

  // Clock source and buffer use from mode and select
  always_ff @(posedge mclk) begin
    if (reset) begin
      txClkSource <= E1TM_CLK_INTERNAL;
      txBufferBypass <= 1'b1;
    end else if (clkMaster) begin
      txClkSource <= clkSourceSel ? E1TM_CLK_RECOVERED : E1TM_CLK_INTERNAL;
      txBufferBypass <= 1'b1;
    end else begin
      txClkSource <= clkSourceSel ? E1TM_CLK_INTERNAL : E1TM_CLK_BACKPLANE;
      txBufferBypass <= ~clkSourceSel;
    end
  end

endmodule : e1tm_tx_framer_maint

/* File: tb/e1tm_tx_framer_maint_monitor.sv */
`timescale 1ns/1ps
// ****
// Port checker
// ****
module e1tm_tx_framer_maint_monitor
  import e1tm_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [11:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic txDataIn,
  input wire logic rxFrameLoss,
  input wire logic rxCrcInterwork,
  input wire logic rxOfflineLoss,
  input wire logic txLineData,
  input wire logic txBitStrobe,
  input wire logic txIrqN,
  input wire e1tm_clk_src_t txClkSource,
  input wire logic txBufferBypass
);
  logic [1:0] quietCnt;
  logic onesReg, zeroReg, masterReg, selReg;
  logic [4:0] enReg;
  wire [9:0] idx = address[11:2];
  wire accW = write && !waitrequest && byteenable[0];
  wire quiet = quietCnt == 2'h3;
  wire mapped = idx == IDX_FRAME_MODE || (idx >= IDX_TX_ALARM && idx <= IDX_CLK_SOURCE);

  // Shadows of the written controls and cycles since the last write
  always_ff @(posedge mclk) begin
    if (reset) begin
      quietCnt <= 2'h0;
      {onesReg, zeroReg, masterReg, selReg, enReg} <= 9'h000;
    end else begin
      quietCnt <= (write && !waitrequest) ? 2'h0 : (quiet ? 2'h3 : quietCnt + 2'h1);
      if (accW && idx == IDX_TX_MAINT) begin
        onesReg <= writedata[MNT_ONES_FORCE];
        zeroReg <= writedata[MNT_ZERO_FORCE];
      end
      if (accW && idx == IDX_FRAME_MODE) masterReg <= writedata[MODE_CLK_MASTER];
      if (accW && idx == IDX_CLK_SOURCE) selReg <= writedata[0];
      if (accW && idx == IDX_IRQ_ENABLE) enReg <= writedata[4:0];
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  property p_oneWait; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_oneWait: assert property (p_oneWait) else $error("bus answer late");
  property p_readHigh; read && !waitrequest |-> readdata[31:8] == 24'h00_0000; endproperty
  a_readHigh: assert property (p_readHigh) else $error("upper read bits set");
  property p_unmapped; read && !waitrequest && !mapped |-> readdata == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_zero; quiet && zeroReg && txBitStrobe |-> !txLineData; endproperty
  a_zero: assert property (p_zero) else $error("line bit not zero");
  property p_ones; quiet && onesReg && !zeroReg && txBitStrobe |-> txLineData; endproperty
  a_ones: assert property (p_ones) else $error("line bit not one");
  property p_irqOff; quiet && enReg == 5'h00 |-> txIrqN; endproperty
  a_irqOff: assert property (p_irqOff) else $error("irq with no enable");
  property p_irqHold; !txIrqN && !write && !$past(write) |=> !txIrqN; endproperty
  a_irqHold: assert property (p_irqHold) else $error("irq dropped alone");
  property p_srcMaster;
    quiet && masterReg |-> txBufferBypass &&
      txClkSource == (selReg ? E1TM_CLK_RECOVERED : E1TM_CLK_INTERNAL);
  endproperty
  a_srcMaster: assert property (p_srcMaster) else $error("master clock wrong");
  property p_srcSlave;
    quiet && !masterReg |-> txBufferBypass == !selReg &&
      txClkSource == (selReg ? E1TM_CLK_INTERNAL : E1TM_CLK_BACKPLANE);
  endproperty
  a_srcSlave: assert property (p_srcSlave) else $error("slave clock wrong");
  property p_strobeGap; txBitStrobe |=> !txBitStrobe [*8]; endproperty
  a_strobeGap: assert property (p_strobeGap) else $error("bit strobes too close");

  c_irq: cover property (!txIrqN);
  c_ones: cover property (quiet && onesReg && txBitStrobe);
  c_master: cover property (quiet && masterReg && selReg);
endmodule : e1tm_tx_framer_maint_monitor

bind e1tm_tx_framer_maint e1tm_tx_framer_maint_monitor u_monitor (
  .mclk(mclk), .reset(reset), .address(address), .read(read), .write(write),
  .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .txDataIn(txDataIn), .rxFrameLoss(rxFrameLoss),
  .rxCrcInterwork(rxCrcInterwork), .rxOfflineLoss(rxOfflineLoss),
  .txLineData(txLineData), .txBitStrobe(txBitStrobe), .txIrqN(txIrqN),
  .txClkSource(txClkSource), .txBufferBypass(txBufferBypass));

/* File: tb/e1tm_line_model.sv */
`timescale 1ns/1ps
// ****
// Line and backplane model
// ****
module e1tm_line_model
  import e1tm_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic txLineData,
  input wire logic txBitStrobe,
  output logic txDataIn,
  output logic [7:0] lastByte,
  output logic [7:0] ts0Byte,
  output logic ts0Done,
  output logic ts0Odd
);
  logic [7:0] bitPos;
  logic frameOdd;

  // Collects line bits, tracks frame position, feeds a changing payload
  always_ff @(posedge mclk) begin
    ts0Done <= 1'b0;
    if (reset) begin
      {bitPos, frameOdd, lastByte, ts0Byte, ts0Odd, txDataIn} <= 27'h000_0000;
    end else if (txBitStrobe) begin
      lastByte <= {lastByte[6:0], txLineData};
      bitPos <= bitPos + 8'h01;
      txDataIn <= ~txDataIn; // Payload never rests at the last level
      if (bitPos == 8'h07) begin
        ts0Byte <= {lastByte[6:0], txLineData};
        ts0Done <= 1'b1;
        ts0Odd <= frameOdd;
      end
      if (bitPos == 8'hff) frameOdd <= ~frameOdd;
    end
  end
endmodule : e1tm_line_model

/* File: tb/test_e1tm_tx_framer_maint.sv */
`timescale 1ns/1ps
module test_e1tm_tx_framer_maint
  import e1tm_pkg::*;
();
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [11:0] address = 12'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] writedata = 32'h0000_0000;
  logic rxFrameLoss = 1'b0;
  logic rxCrcInterwork = 1'b0;
  logic rxOfflineLoss = 1'b0;
  logic [31:0] readdata, rd;
  logic waitrequest, txDataIn, txLineData, txBitStrobe, txIrqN, txBufferBypass;
  e1tm_clk_src_t txClkSource;
  logic [7:0] lastByte, ts0Byte, rnd;
  logic ts0Done, ts0Odd;
  int n_fail = 0;
  int comparisons = 0;
  int i;

  always #5 mclk = ~mclk;

  e1tm_tx_framer_maint DUT (.mclk(mclk), .reset(reset), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .txDataIn(txDataIn), .rxFrameLoss(rxFrameLoss),
    .rxCrcInterwork(rxCrcInterwork), .rxOfflineLoss(rxOfflineLoss),
    .txLineData(txLineData), .txBitStrobe(txBitStrobe), .txIrqN(txIrqN),
    .txClkSource(txClkSource), .txBufferBypass(txBufferBypass));
  e1tm_line_model u_line (.mclk(mclk), .reset(reset), .txLineData(txLineData),
    .txBitStrobe(txBitStrobe), .txDataIn(txDataIn), .lastByte(lastByte),
    .ts0Byte(ts0Byte), .ts0Done(ts0Done), .ts0Odd(ts0Odd));

  // ****
  // Tasks
  // ****
  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task timedOut;
    n_fail++;
    summarize();
  endtask : timedOut

  // One register access; holds the request until waitrequest is seen low
  task bus(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    int n;
    @(posedge mclk);
    address <= {idx, 2'b00};
    writedata <= {24'h00_0000, d};
    write <= wr;
    read <= !wr;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) timedOut();
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus

  task waitStrobes(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 5000) begin
      @(posedge mclk);
      k++;
      if (txBitStrobe === 1'b1) n--;
    end
    if (n > 0) timedOut();
  endtask : waitStrobes

  // Waits for timeslot 0 of the next even or odd frame to be captured
  task waitTs0(input logic odd);
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (!(ts0Done === 1'b1 && ts0Odd === odd) && k < 40000);
    if (k >= 40000) timedOut();
  endtask : waitTs0

  function automatic logic [2:0] clkExp(input logic m, input logic s);
    if (m) clkExp = {s ? E1TM_CLK_RECOVERED : E1TM_CLK_INTERNAL, 1'b1};
    else clkExp = {s ? E1TM_CLK_INTERNAL : E1TM_CLK_BACKPLANE, !s};
  endfunction : clkExp

  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(54343));
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    bus(1'b1, IDX_FRAME_MODE, 8'h03);
    for (i = 'h06c; i <= 'h071; i++) begin
      bus(1'b0, i[9:0], 8'h00);
      check(rd, 32'h0000_0000);
    end
    waitStrobes(2);
    bus(1'b0, IDX_IRQ_FLAGS, 8'h00);
    check(rd, 32'h0000_001f);
    check({31'h0, txIrqN}, 32'h0000_0001);
    bus(1'b1, IDX_IRQ_FLAGS, 8'h00);
    bus(1'b0, IDX_IRQ_FLAGS, 8'h00);
    check(rd, 32'h0000_001f);
    bus(1'b1, IDX_IRQ_FLAGS, 8'h01);
    bus(1'b0, IDX_IRQ_FLAGS, 8'h00);
    check(rd, 32'h0000_001e);
    bus(1'b1, IDX_IRQ_ENABLE, 8'h02);
    repeat (3) @(posedge mclk);
    check({31'h0, txIrqN}, 32'h0000_0000);
    repeat (3) @(posedge mclk);
    check({31'h0, txIrqN}, 32'h0000_0000);
    bus(1'b1, IDX_IRQ_FLAGS, 8'h02);
    repeat (3) @(posedge mclk);
    check({31'h0, txIrqN}, 32'h0000_0001);
    rnd = 8'($urandom);
    bus(1'b1, IDX_IRQ_ENABLE, {3'h0, rnd[4:0]});
    bus(1'b0, IDX_IRQ_ENABLE, 8'h00);
    check(rd, {27'h000_0000, rnd[4:0]});
    // A write without lane 0 enabled must leave the register alone
    byteenable <= 4'he;
    bus(1'b1, IDX_IRQ_ENABLE, {3'h0, ~rnd[4:0]});
    byteenable <= 4'hf;
    bus(1'b0, IDX_IRQ_ENABLE, 8'h00);
    check(rd, {27'h000_0000, rnd[4:0]});
    bus(1'b1, IDX_IRQ_ENABLE, 8'h00);
    for (i = 0; i < 4; i++) begin
      bus(1'b1, IDX_FRAME_MODE, {5'h00, i[1], 2'b11});
      bus(1'b1, IDX_CLK_SOURCE, {7'h00, i[0]});
      repeat (3) @(posedge mclk);
      check({29'h0, txClkSource, txBufferBypass}, {29'h0, clkExp(i[1], i[0])});
    end
    bus(1'b1, IDX_FRAME_MODE, 8'h03);
    waitTs0(1'b1);
    bus(1'b1, IDX_ERR_INSERT, 8'h06);
    bus(1'b1, IDX_TX_ALARM, 8'h01);
    waitTs0(1'b0);
    check({25'h0, ts0Byte[6:0]}, {25'h0, ~FAS_PATTERN});
    bus(1'b0, IDX_ERR_INSERT, 8'h00);
    check(rd, 32'h0000_0004);
    // Forcing runs in the payload of this frame and is gone before the next TS0
    bus(1'b1, IDX_TX_MAINT, 8'h01);
    waitStrobes(10);
    check({24'h0, lastByte}, 32'h0000_00ff);
    bus(1'b1, IDX_TX_MAINT, 8'h03);
    waitStrobes(10);
    check({24'h0, lastByte}, 32'h0000_0000);
    bus(1'b1, IDX_TX_MAINT, 8'h00);
    waitTs0(1'b1);
    check({30'h0, ts0Byte[6:5]}, 32'h0000_0001);
    bus(1'b0, IDX_ERR_INSERT, 8'h00);
    check(rd, 32'h0000_0000);
    // Single alignment bit error in the next even frame
    bus(1'b1, IDX_ERR_INSERT, 8'h01);
    waitTs0(1'b0);
    check({25'h0, ts0Byte[6:0]}, {25'h0, FAS_PATTERN ^ 7'h40});
    bus(1'b0, IDX_ERR_INSERT, 8'h00);
    check(rd, 32'h0000_0000);
    rxCrcInterwork <= 1'b1;
    bus(1'b1, IDX_TX_ALARM, 8'h02);
    waitTs0(1'b1);
    check({30'h0, ts0Byte[6:5]}, 32'h0000_0003);
    bus(1'b1, IDX_TX_ALARM, 8'h06);
    waitTs0(1'b1);
    check({30'h0, ts0Byte[6:5]}, 32'h0000_0002);
    // Slip last: the line model stays one bit off, ahead or behind
    bus(1'b1, IDX_TX_MAINT, 8'h04);
    waitTs0(1'b0);
    check({31'h0, (ts0Byte[7:1] == FAS_PATTERN) || (ts0Byte[5:0] == FAS_PATTERN[6:1])},
      32'h0000_0001);
    summarize();
  end
endmodule : test_e1tm_tx_framer_maint
